// ---- common/dds_tuning_pkg.sv ----
// constants, field layouts and carrier types for the tuning register bank
// assumes one master clock domain; command words arrive already deserialised
// Function
// - two 28-bit frequency words and two 12-bit phase words are held
// - output frequency is clock times selected frequency word over two to 28
// - selected phase word adds to accumulator output, 2pi/4096 per unit
// - source bit 1 lets pins select words, 0 lets control bits select
// - frequency selector 0 picks word zero, 1 picks word one
// - phase selector 0 adds phase word zero, 1 adds phase word one
// - top two command bits: 00 control, 01 freq_tuning_word_zero, 10 freq_tuning_word_one, 11 phase
// - full-word mode loads 14 low bits then 14 high bits, same address
// - split mode: half bit 0 writes low half, 1 writes high half
// - phase load: bit 13 picks word, bit 12 ignored, bits 11..0 value
// - reset clears accumulation to zero, keeps frequency, phase, control words
// - output reappears seven clock cycles after reset release
// - reset from control bit when source bit 0, from pin when 1
// - reset pin asserts immediately; its release is sampled on clock
package dds_tuning_pkg;
  localparam int FREQ_W = 28;
  localparam int PHASE_W = 12;
  localparam int HALF_W = 14;
  localparam int CMD_W = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 14;
  localparam int FULL_WORD_POS = 13;
  localparam int HALF_PICK_POS = 12;
  localparam int PHASE_PICK_POS = 13;
  localparam int RESET_BIT_POS = 8;
  localparam int SOURCE_POS = 9;
  localparam int PHASE_BIT_POS = 10;
  localparam int FREQ_BIT_POS = 11;
  localparam int OUT_DELAY_CYC = 7;
  localparam logic [FREQ_W-1:0] ACC_RST = 28'h0000000;
  localparam logic [CMD_W-1:0] CTRL_RST = 16'h0000;

  typedef enum logic [1:0] {
    CMD_CTRL = 2'b00,
    CMD_FREQ_TUNING_WORD_ZERO = 2'b01,
    CMD_FREQ_TUNING_WORD_ONE = 2'b10,
    CMD_PHASE = 2'b11
  } cmd_type;

  typedef struct packed {
    logic full_word;
    logic half_pick;
    logic freq_bit;
    logic phase_bit;
    logic source;
    logic reset_bit;
  } ctrl_type;

  typedef struct packed {
    logic [FREQ_W-1:0] phase_acc;
    logic [PHASE_W-1:0] phase_out;
    logic out_valid;
  } nco_out_type;
endpackage

// ---- design/dds_tuning_register_control.sv ----
// tuning word storage, selection and phase accumulation for the synthesizer
// assumes command words arrive parallel with a one-cycle strobe from the serial front end
`timescale 1ns/1ps
module dds_tuning_register_control
  import dds_tuning_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // command word
  input wire logic [CMD_W-1:0] cmd_word,
  input wire logic cmd_valid,
  // pins
  input wire logic freq_choice_pin,
  input wire logic phase_choice_pin,
  input wire logic reset_pin,
  // accumulator, selected word and engine reset outputs
  output nco_out_type nco_ff,
  output logic [FREQ_W-1:0] selected_freq_value_ff,
  output logic [PHASE_W-1:0] selected_phase_value_ff,
  output logic engine_reset_ff
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic pick(input logic src, input logic pin_v, input logic bit_v);
    pick = src ? pin_v : bit_v;
  endfunction

  function automatic logic [FREQ_W-1:0] put_half(input logic [FREQ_W-1:0] old,
                                                 input logic [HALF_W-1:0] val,
                                                 input logic hi);
    put_half = hi ? {val, old[HALF_W-1:0]} : {old[FREQ_W-1:HALF_W], val};
  endfunction

  function automatic logic is_cmd(input logic valid, input cmd_type got, input cmd_type want);
    is_cmd = valid && (got == want);
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [FREQ_W-1:0] freq_tuning_word_zero_ff;
  logic [FREQ_W-1:0] freq_tuning_word_one_ff;
  logic [PHASE_W-1:0] phase_offset_word_zero_ff;
  logic [PHASE_W-1:0] phase_offset_word_one_ff;
  ctrl_type ctrl_ff;
  logic full_next_hi0_ff;
  logic full_next_hi1_ff;
  cmd_type cmd;
  logic [HALF_W-1:0] cmd_data;

  assign cmd = cmd_type'(cmd_word[ADDR_MSB:ADDR_LSB]);
  assign cmd_data = cmd_word[HALF_W-1:0];

  // one-cycle load strobes, already gated by the clock enable
  logic load_ctrl;
  logic load_freq_tuning_word_zero;
  logic load_freq_tuning_word_one;
  logic load_phase;

  assign load_ctrl = clk_en && is_cmd(cmd_valid, cmd, CMD_CTRL);
  assign load_freq_tuning_word_zero = clk_en && is_cmd(cmd_valid, cmd, CMD_FREQ_TUNING_WORD_ZERO);
  assign load_freq_tuning_word_one = clk_en && is_cmd(cmd_valid, cmd, CMD_FREQ_TUNING_WORD_ONE);
  assign load_phase = clk_en && is_cmd(cmd_valid, cmd, CMD_PHASE);

  // control word; held across engine reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ctrl_ff <= ctrl_type'(6'h00);
    else if (load_ctrl)
    begin
      ctrl_ff.full_word <= cmd_word[FULL_WORD_POS];
      ctrl_ff.half_pick <= cmd_word[HALF_PICK_POS];
      ctrl_ff.freq_bit <= cmd_word[FREQ_BIT_POS];
      ctrl_ff.phase_bit <= cmd_word[PHASE_BIT_POS];
      ctrl_ff.source <= cmd_word[SOURCE_POS];
      ctrl_ff.reset_bit <= cmd_word[RESET_BIT_POS];
    end
  end

  // frequency words; full-word mode alternates low then high half
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      freq_tuning_word_zero_ff <= ACC_RST;
      freq_tuning_word_one_ff <= ACC_RST;
      full_next_hi0_ff <= 1'b0;
      full_next_hi1_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cmd_valid && cmd == CMD_CTRL)
      begin
        full_next_hi0_ff <= 1'b0;
        full_next_hi1_ff <= 1'b0;
      end
      else if (cmd_valid && cmd == CMD_FREQ_TUNING_WORD_ZERO)
      begin
        if (ctrl_ff.full_word)
        begin
          freq_tuning_word_zero_ff <= put_half(freq_tuning_word_zero_ff, cmd_data, full_next_hi0_ff);
          full_next_hi0_ff <= ~full_next_hi0_ff;
        end
        else
          freq_tuning_word_zero_ff <= put_half(freq_tuning_word_zero_ff, cmd_data, ctrl_ff.half_pick);
      end
      else if (cmd_valid && cmd == CMD_FREQ_TUNING_WORD_ONE)
      begin
        if (ctrl_ff.full_word)
        begin
          freq_tuning_word_one_ff <= put_half(freq_tuning_word_one_ff, cmd_data, full_next_hi1_ff);
          full_next_hi1_ff <= ~full_next_hi1_ff;
        end
        else
          freq_tuning_word_one_ff <= put_half(freq_tuning_word_one_ff, cmd_data, ctrl_ff.half_pick);
      end
    end
  end

  // phase words
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      phase_offset_word_zero_ff <= 12'h000;
      phase_offset_word_one_ff <= 12'h000;
    end
    else if (load_phase)
    begin
      if (cmd_word[PHASE_PICK_POS])
        phase_offset_word_one_ff <= cmd_word[PHASE_W-1:0];
      else
        phase_offset_word_zero_ff <= cmd_word[PHASE_W-1:0];
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      pin_meta_ff <= {reset_pin, phase_choice_pin, freq_choice_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------
  // selection
  // ----------------------------------------
  logic freq_sel;
  logic phase_sel;
  logic eng_rst_req;

  assign freq_sel = pick(ctrl_ff.source, pin_sync_ff[0], ctrl_ff.freq_bit);
  assign phase_sel = pick(ctrl_ff.source, pin_sync_ff[1], ctrl_ff.phase_bit);
  // pin assertion bypasses sync; release waits for synchronised low
  assign eng_rst_req = ctrl_ff.source ? (reset_pin | pin_sync_ff[2]) : ctrl_ff.reset_bit;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      selected_freq_value_ff <= ACC_RST;
      selected_phase_value_ff <= 12'h000;
    end
    else if (clk_en)
    begin
      selected_freq_value_ff <= freq_sel ? freq_tuning_word_one_ff : freq_tuning_word_zero_ff;
      selected_phase_value_ff <= phase_sel ? phase_offset_word_one_ff : phase_offset_word_zero_ff;
    end
  end

  // ----------------------------------------
  // accumulator and output delay
  // ----------------------------------------
  logic [2:0] delay_cnt_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      engine_reset_ff <= 1'b1;
    else if (clk_en)
      engine_reset_ff <= eng_rst_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clk_en && eng_rst_req))
    begin
      nco_ff <= '0;
      delay_cnt_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      nco_ff.phase_acc <= nco_ff.phase_acc + selected_freq_value_ff;
      nco_ff.phase_out <= nco_ff.phase_acc[FREQ_W-1:FREQ_W-PHASE_W] + selected_phase_value_ff;
      if (delay_cnt_ff != 3'(OUT_DELAY_CYC - 1))
        delay_cnt_ff <= delay_cnt_ff + 3'h1;
      nco_ff.out_valid <= (delay_cnt_ff == 3'(OUT_DELAY_CYC - 1));
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // enabled edges since the engine left reset; saturates at the delay
  logic [3:0] since_rel_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      since_rel_ff <= 4'h0;
    else if (clk_en)
    begin
      if (eng_rst_req)
        since_rel_ff <= 4'h0;
      else if (since_rel_ff != 4'(OUT_DELAY_CYC))
        since_rel_ff <= since_rel_ff + 4'h1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  reset_clears_acc_a: assert property ((clk_en && eng_rst_req) |=> nco_ff.phase_acc == '0)
    else $error("accumulator not cleared by reset");
  output_delay_a: assert property (($fell(engine_reset_ff) && clk_en && !eng_rst_req)
      ##1 (clk_en && !eng_rst_req) [*5] |=> nco_ff.out_valid)
    else $error("output not back after seven cycles");
  no_early_out_a: assert property ((clk_en && eng_rst_req) |=> !nco_ff.out_valid)
    else $error("output valid during reset");
  acc_step_a: assert property ((clk_en && !eng_rst_req) |=>
      nco_ff.phase_acc == $past(nco_ff.phase_acc) + $past(selected_freq_value_ff))
    else $error("accumulator step wrong");
  freq_pick_a: assert property ((clk_en && !freq_sel) |=> selected_freq_value_ff == $past(freq_tuning_word_zero_ff))
    else $error("frequency word zero not selected");
  phase_pick_a: assert property ((clk_en && phase_sel) |=> selected_phase_value_ff == $past(phase_offset_word_one_ff))
    else $error("phase word one not selected");
  pin_reset_a: assert property ((clk_en && ctrl_ff.source && reset_pin) |=> engine_reset_ff)
    else $error("reset pin not immediate");
  bit_reset_a: assert property ((clk_en && !ctrl_ff.source) |=> engine_reset_ff == $past(ctrl_ff.reset_bit))
    else $error("reset bit not followed");
  phase_load_a: assert property ((clk_en && cmd_valid && cmd == CMD_PHASE && !cmd_word[PHASE_PICK_POS])
      |=> phase_offset_word_zero_ff == $past(cmd_word[PHASE_W-1:0]))
    else $error("phase word zero load wrong");
  split_low_a: assert property ((clk_en && cmd_valid && cmd == CMD_FREQ_TUNING_WORD_ONE && !ctrl_ff.full_word && !ctrl_ff.half_pick)
      |=> freq_tuning_word_one_ff[HALF_W-1:0] == $past(cmd_data))
    else $error("low half load wrong");

  // ----------------------------------------
  // checks: storage
  // ----------------------------------------
  ctrl_load_a: assert property (load_ctrl |=> ctrl_ff.source == $past(cmd_word[SOURCE_POS]))
    else $error("source bit not loaded");
  toggle_clear_a: assert property (load_ctrl |=> !full_next_hi0_ff && !full_next_hi1_ff)
    else $error("full word order not restarted");
  full_low_a: assert property ((load_freq_tuning_word_zero && ctrl_ff.full_word && !full_next_hi0_ff)
      |=> freq_tuning_word_zero_ff[HALF_W-1:0] == $past(cmd_data))
    else $error("full word low half wrong");
  full_high_a: assert property ((load_freq_tuning_word_zero && ctrl_ff.full_word && full_next_hi0_ff)
      |=> freq_tuning_word_zero_ff == {$past(cmd_data), $past(freq_tuning_word_zero_ff[HALF_W-1:0])})
    else $error("full word high half wrong");
  full_one_a: assert property ((load_freq_tuning_word_one && ctrl_ff.full_word)
      |=> full_next_hi1_ff != $past(full_next_hi1_ff))
    else $error("full word order not advanced");
  split_high_a: assert property ((load_freq_tuning_word_zero && !ctrl_ff.full_word && ctrl_ff.half_pick)
      |=> freq_tuning_word_zero_ff == {$past(cmd_data), $past(freq_tuning_word_zero_ff[HALF_W-1:0])})
    else $error("high half load wrong");
  split_keep_a: assert property ((load_freq_tuning_word_one && !ctrl_ff.full_word && !ctrl_ff.half_pick)
      |=> freq_tuning_word_one_ff[FREQ_W-1:HALF_W] == $past(freq_tuning_word_one_ff[FREQ_W-1:HALF_W]))
    else $error("high half disturbed by low write");
  phase_one_load_a: assert property ((load_phase && cmd_word[PHASE_PICK_POS])
      |=> phase_offset_word_one_ff == $past(cmd_word[PHASE_W-1:0])
      && phase_offset_word_zero_ff == $past(phase_offset_word_zero_ff))
    else $error("phase word one load wrong");
  phase_ignore_a: assert property ((load_phase && !cmd_word[PHASE_PICK_POS])
      |=> phase_offset_word_one_ff == $past(phase_offset_word_one_ff))
    else $error("phase word one disturbed");
  words_kept_a: assert property ((clk_en && eng_rst_req && !cmd_valid)
      |=> freq_tuning_word_zero_ff == $past(freq_tuning_word_zero_ff)
      && freq_tuning_word_one_ff == $past(freq_tuning_word_one_ff)
      && ctrl_ff == $past(ctrl_ff))
    else $error("engine reset touched stored words");
  freeze_words_a: assert property (!clk_en |=> freq_tuning_word_zero_ff == $past(freq_tuning_word_zero_ff)
      && freq_tuning_word_one_ff == $past(freq_tuning_word_one_ff) && ctrl_ff == $past(ctrl_ff)
      && phase_offset_word_zero_ff == $past(phase_offset_word_zero_ff)
      && phase_offset_word_one_ff == $past(phase_offset_word_one_ff))
    else $error("stored words moved while frozen");

  // ----------------------------------------
  // checks: selection
  // ----------------------------------------
  freq_one_pick_a: assert property ((clk_en && freq_sel)
      |=> selected_freq_value_ff == $past(freq_tuning_word_one_ff))
    else $error("frequency word one not selected");
  phase_zero_pick_a: assert property ((clk_en && !phase_sel)
      |=> selected_phase_value_ff == $past(phase_offset_word_zero_ff))
    else $error("phase word zero not selected");
  bit_choice_a: assert property ((clk_en && !ctrl_ff.source && !ctrl_ff.freq_bit)
      |=> selected_freq_value_ff == $past(freq_tuning_word_zero_ff))
    else $error("control bit not steering the frequency word");
  freeze_sel_a: assert property (!clk_en |=> selected_freq_value_ff == $past(selected_freq_value_ff)
      && selected_phase_value_ff == $past(selected_phase_value_ff) && pin_sync_ff == $past(pin_sync_ff))
    else $error("selection moved while frozen");

  // ----------------------------------------
  // checks: engine
  // ----------------------------------------
  out_count_a: assert property (nco_ff.out_valid == (since_rel_ff == 4'(OUT_DELAY_CYC)))
    else $error("output back at the wrong cycle");
  delay_bound_a: assert property (delay_cnt_ff <= 3'(OUT_DELAY_CYC - 1))
    else $error("delay counter overran");
  valid_hold_a: assert property ((clk_en && !eng_rst_req && nco_ff.out_valid) |=> nco_ff.out_valid)
    else $error("output dropped without reset");
  phase_add_a: assert property ((clk_en && !eng_rst_req)
      |=> nco_ff.phase_out == $past(nco_ff.phase_acc[FREQ_W-1:FREQ_W-PHASE_W]) + $past(selected_phase_value_ff))
    else $error("phase offset not added");
  pin_release_a: assert property ((clk_en && ctrl_ff.source && pin_sync_ff[2]) |=> engine_reset_ff)
    else $error("reset pin released before sampling");
  pin_source_reset_a: assert property ((clk_en && ctrl_ff.source && !reset_pin && !pin_sync_ff[2])
      |=> !engine_reset_ff)
    else $error("reset bit acted while pins rule");
  freeze_acc_a: assert property (!clk_en
      |=> nco_ff == $past(nco_ff) && delay_cnt_ff == $past(delay_cnt_ff))
    else $error("accumulator moved while frozen");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  full_load_c: cover property (clk_en && cmd_valid && cmd == CMD_FREQ_TUNING_WORD_ZERO && ctrl_ff.full_word && full_next_hi0_ff);
  pin_select_c: cover property (clk_en && ctrl_ff.source && freq_sel);
  restart_c: cover property (nco_ff.out_valid && $past(!nco_ff.out_valid));
  split_load_c: cover property (load_freq_tuning_word_one && !ctrl_ff.full_word && ctrl_ff.half_pick);
  pin_reset_c: cover property (clk_en && ctrl_ff.source && reset_pin);
endmodule

// ---- bench/dds_host_model.sv ----
// host model: sends command words and drives the select and reset pins
// assumes the receiving block takes a word on a rising edge with cmd_valid high
`timescale 1ns/1ps
module dds_host_model
  import dds_tuning_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // command and pins
  output logic [CMD_W-1:0] cmd_word,
  output logic cmd_valid,
  output logic freq_choice_pin,
  output logic phase_choice_pin,
  output logic reset_pin
);
  initial
  begin
    cmd_word = 16'h0000;
    cmd_valid = 1'b0;
    freq_choice_pin = 1'b0;
    phase_choice_pin = 1'b0;
    reset_pin = 1'b0;
  end

  // one word per call, inverse data once released
  task automatic send(input logic [CMD_W-1:0] w);
    @(posedge sys_clk);
    #1 cmd_word = w;
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask

  // pins change only off the sampling edge and stay steady otherwise
  task automatic pins(input logic f, input logic p, input logic r);
    @(posedge sys_clk);
    #1 freq_choice_pin = f;
    phase_choice_pin = p;
    reset_pin = r;
  endtask
endmodule

// ---- bench/test_dds_tuning_register_control.sv ----
// testbench: command sequences with expected selected words and engine state
// assumes the host model and the package are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_dds_tuning_register_control;
  import dds_tuning_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [CMD_W-1:0] cmd_word;
  logic cmd_valid, fpin, ppin, rpin, eng_rst;
  nco_out_type nco;
  logic [FREQ_W-1:0] sel_f, acc;
  logic [PHASE_W-1:0] sel_p, ph;
  int err_total = 0;
  int total_checks = 0;

  always #4 sys_clk = ~sys_clk;

  dds_host_model u_host (.sys_clk(sys_clk), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .freq_choice_pin(fpin), .phase_choice_pin(ppin), .reset_pin(rpin));

  dds_tuning_register_control u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .freq_choice_pin(fpin),
    .phase_choice_pin(ppin), .reset_pin(rpin), .nco_ff(nco),
    .selected_freq_value_ff(sel_f), .selected_phase_value_ff(sel_p), .engine_reset_ff(eng_rst));

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // --------------------------------
  // watchdog
  // --------------------------------
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end

  // --------------------------------
  // tests
  // --------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    u_host.send(16'h2000);
    u_host.send(16'h4000);
    u_host.send(16'h7fff);
    wt(4);
    `CHK("freq_tuning_word_zero full", 28'hfffc000, sel_f)
    $display("test full word done");
    u_host.send(16'h0000);
    u_host.send(16'hbfff);
    u_host.send(16'h0800);
    wt(4);
    `CHK("freq_tuning_word_one low", 28'h0003fff, sel_f)
    u_host.send(16'h1000);
    u_host.send(16'h80ff);
    u_host.send(16'h0800);
    wt(4);
    `CHK("freq_tuning_word_one high", 28'h03fffff, sel_f)
    $display("test half word done");
    u_host.send(16'hdabc);
    u_host.send(16'he123);
    u_host.send(16'h0400);
    wt(4);
    `CHK("phase_offset_word_one", 12'h123, sel_p)
    u_host.send(16'h0000);
    wt(4);
    `CHK("phase_offset_word_zero", 12'habc, sel_p)
    `CHK("freq_tuning_word_zero back", 28'hfffc000, sel_f)
    $display("test phase done");
    u_host.pins(1'b1, 1'b1, 1'b0);
    u_host.send(16'h0200);
    wt(5);
    `CHK("pin freq_tuning_word_one", 28'h03fffff, sel_f)
    `CHK("pin phase_offset_word_one", 12'h123, sel_p)
    u_host.pins(1'b0, 1'b0, 1'b0);
    u_host.send(16'h0e00);
    wt(5);
    `CHK("pin freq_tuning_word_zero", 28'hfffc000, sel_f)
    `CHK("pin phase_offset_word_zero", 12'habc, sel_p)
    $display("test pins done");
    u_host.send(16'h0100);
    wt(3);
    `CHK("bit reset", 1'b1, eng_rst)
    `CHK("acc clear", 28'h0000000, nco.phase_acc)
    `CHK("words kept", 28'hfffc000, sel_f)
    u_host.send(16'h0000);
    wt(6);
    `CHK("early out", 1'b0, nco.out_valid)
    wt(1);
    `CHK("out back", 1'b1, nco.out_valid)
    acc = nco.phase_acc;
    ph = sel_p;
    wt(1);
    `CHK("acc step", acc + 28'hfffc000, nco.phase_acc)
    `CHK("phase add", acc[FREQ_W-1:FREQ_W-PHASE_W] + ph, nco.phase_out)
    $display("test bit reset done");
    clk_en = 1'b0;
    acc = nco.phase_acc;
    u_host.send(16'h0800);
    wt(2);
    `CHK("freeze acc", acc, nco.phase_acc)
    `CHK("freeze select", 28'hfffc000, sel_f)
    clk_en = 1'b1;
    wt(1);
    `CHK("thaw acc", acc + 28'hfffc000, nco.phase_acc)
    `CHK("frozen cmd dropped", 28'hfffc000, sel_f)
    $display("test freeze done");
    u_host.send(16'h0300);
    wt(3);
    `CHK("pin ignores bit", 1'b0, eng_rst)
    u_host.pins(1'b0, 1'b0, 1'b1);
    wt(1);
    `CHK("pin reset", 1'b1, eng_rst)
    wt(2);
    `CHK("pin acc clear", 28'h0000000, nco.phase_acc)
    u_host.pins(1'b0, 1'b0, 1'b0);
    wt(14);
    `CHK("pin out back", 1'b1, nco.out_valid)
    $display("test pin reset done");
    close_out();
  end
endmodule
